// ---- hw/gpp_port_map.vh ----
/*
 * Register offsets, reset values and the bit layouts of the GPIO port block.
 * Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
 */
// How it works
// - Writes to latch register or pin-level register store into the same latch.
// - Latch read returns stored latch; pin-level read returns sampled pin levels.
// - Direction 1 disables the driver; 0 drives the latch bit, analog too.
// - Analog select 1 forces pin-level and peripheral input values to zero, except an active master-clear port bit.
// - Analog select never changes output driving.
// - Analog select bits reset to analog; software clears them for digital use.
// - Pull-up bit 1 enables weak pull-up, 0 disables, per pin.
// - Threshold bit picks Schmitt or TTL input for reads and peripherals.
// - Slew bit 1 requests limited slew, 0 maximum rate, per pin.
// - Open-drain bit 1 makes output sink-only; 0 is push-pull.
// - Each pin can flag rising or falling input edges.
// - I2C pad controls for slew, pull-up, threshold; peripherals see I2C levels.
// - After reset every pin is an input: direction resets to 1, so no latch bit is driven.
// - An enabled analog output floats the digital output driver.
// - Priority: configuration, analog output, then port and peripheral; analog input select is ignored.
// - Master-clear pin is input-only port pin when master-clear enable and low-voltage prog enable are both 0.
// - Master-clear port bit reads 1 whenever master-clear function is enabled.
// - Master-clear pull-up forced on when enabled without low-voltage prog, or prog set.
// - Pin-level and latch keep contents across resets other than power-on.
// - Bits of unimplemented pins always read zero.
// - Pull-up turns off for output pins without changing the stored bit.
`ifndef GPP_PORT_MAP_VH
`define GPP_PORT_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPP_OFS_PIN_LEVEL 6'h00
`define GPP_OFS_LATCH 6'h04
`define GPP_OFS_DIRECTION 6'h08
`define GPP_OFS_ANALOG 6'h0c
`define GPP_OFS_PULLUP 6'h10
`define GPP_OFS_THRESHOLD 6'h14
`define GPP_OFS_SLEW 6'h18
`define GPP_OFS_OPEN_DRAIN 6'h1c
`define GPP_OFS_EDGE_RISE 6'h20
`define GPP_OFS_EDGE_FALL 6'h24
`define GPP_OFS_EDGE_FLAGS 6'h28
`define GPP_OFS_I2C_PAD 6'h2c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPP_RST_DIRECTION 8'hff
`define GPP_RST_ANALOG 8'hff
`define GPP_RST_PULLUP 8'h00
`define GPP_RST_THRESHOLD 8'hff
`define GPP_RST_SLEW 8'hff
`define GPP_RST_OPEN_DRAIN 8'h00
`define GPP_RST_I2C_PAD 8'h00

// ----------------------------------------
// I2C pad control field positions
// ----------------------------------------
`define GPP_I2C_SLEW_BIT 6
`define GPP_I2C_PU_HI 5
`define GPP_I2C_PU_LO 4
`define GPP_I2C_TH_HI 1
`define GPP_I2C_TH_LO 0
`define GPP_I2C_MASK 8'h73

`endif

// ---- hw/gpp_sync2.v ----
/*
 * Two-flop synchroniser for a bus of pin levels.
 * Assumes inputs are asynchronous to mclk_in; first stage read only by second.
 */
module gpp_sync2 #(
    parameter WIDTH = 8
) (
    input wire mclk_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;

// ----------------------------------------
// Synchroniser stages
// ----------------------------------------
// No reset: pin levels carry no control state
always @(posedge mclk_in) begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
end

endmodule // gpp_sync2

// ---- hw/gpp_port.v ----
/*
 * One 8-bit GPIO port: latch, direction, analog, pull-up, threshold, slew,
 * open-drain, edge detection and master-clear pin handling, behind Wishbone.
 * Assumes the pad ring resolves the pins from out/oe and applies pad controls.
 */
`include "gpp_port_map.vh"

module gpp_port #(
    parameter [7:0] IMPL_MASK = 8'hff,
    parameter [7:0] I2C_PAD_MASK = 8'h00,
    parameter integer MASTER_CLEAR_PIN_BIT = 3,
    parameter HAS_MASTER_CLEAR_PIN = 1'b0
) (
    input wire mclk_in,
    input wire nrst_in,
    input wire por_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [5:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    output reg wb_err_out,
    input wire [7:0] pin_in,
    input wire [7:0] pin_ttl_in,
    input wire [7:0] pin_i2c_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe_out,
    output reg [7:0] pullup_enable_out,
    output reg [7:0] slew_limit_out,
    output reg [7:0] i2c_slew_out,
    output reg [15:0] i2c_pullup_out,
    output reg [15:0] i2c_threshold_out,
    output reg [7:0] periph_in_out,
    output reg [7:0] edge_flags_out,
    input wire [7:0] analog_out_en_in,
    input wire [7:0] cfg_own_in,
    input wire [7:0] cfg_oe_in,
    input wire [7:0] cfg_out_in,
    input wire [7:0] pps_sel_in,
    input wire [7:0] pps_out_in,
    input wire [7:0] i2c_mode_in,
    input wire master_clear_enable_in,
    input wire low_voltage_prog_enable_in
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] latch_reg;
reg [7:0] dir_reg;
reg [7:0] analog_reg;
reg [7:0] pullup_reg;
reg [7:0] thresh_reg;
reg [7:0] slew_reg;
reg [7:0] od_reg;
reg [7:0] rise_en_reg;
reg [7:0] fall_en_reg;
reg [7:0] flags_reg;
reg [7:0] prev_reg;
reg prev_valid_reg;
reg [7:0] i2c_pad_reg [0:7];
reg [2:0] i2c_idx_reg;

wire [7:0] st_sync;
wire [7:0] ttl_sync;
wire [7:0] i2c_sync;

// One loop index per process so no variable has two drivers
integer i;
integer j;
integer k;
integer m;

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Byte-lane 0 merge, used by the latch register only
function [7:0] wr_byte;
    input [7:0] old_val;
    input [31:0] data;
    input [3:0] sel;
    begin
        wr_byte = sel[0] ? data[7:0] : old_val;
    end
endfunction

// Master-clear pin is a plain port pin only when this is false
function master_clear_pin_active;
    input mce;
    input low_voltage_prog_enable;
    begin
        master_clear_pin_active = low_voltage_prog_enable | mce;
    end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Every level path crosses into mclk_in before use
gpp_sync2 #(.WIDTH(8)) u_sync_st (
    .mclk_in(mclk_in),
    .async_in(pin_in),
    .sync_out(st_sync)
);

gpp_sync2 #(.WIDTH(8)) u_sync_ttl (
    .mclk_in(mclk_in),
    .async_in(pin_ttl_in),
    .sync_out(ttl_sync)
);

gpp_sync2 #(.WIDTH(8)) u_sync_i2c (
    .mclk_in(mclk_in),
    .async_in(pin_i2c_in),
    .sync_out(i2c_sync)
);

// ----------------------------------------
// Input selection
// ----------------------------------------
reg [7:0] thr_level;
reg [7:0] dig_level;
reg [7:0] periph_level;
reg [7:0] port_read;
reg [7:0] fixed_mask;
wire master_clear_pin_on = master_clear_pin_active(master_clear_enable_in, low_voltage_prog_enable_in);

// Threshold choice, analog gating and I2C level override
always @* begin
    fixed_mask = 8'h00;
    if (HAS_MASTER_CLEAR_PIN)
        fixed_mask[MASTER_CLEAR_PIN_BIT] = 1'b1;
    thr_level = (thresh_reg & st_sync) | (~thresh_reg & ttl_sync);
    dig_level = thr_level & ~analog_reg & IMPL_MASK;
    periph_level = dig_level;
    for (j = 0; j < 8; j = j + 1) begin
        if (I2C_PAD_MASK[j] && i2c_mode_in[j] && !analog_reg[j])
            periph_level[j] = i2c_sync[j];
    end
    port_read = dig_level;
    if (HAS_MASTER_CLEAR_PIN && master_clear_pin_on)
        port_read[MASTER_CLEAR_PIN_BIT] = 1'b1;
end

// ----------------------------------------
// Output driver and pad control
// ----------------------------------------
reg [7:0] drv_val;
reg [7:0] drv_en;
reg [7:0] pu_eff;

// Fixed priority: configuration, analog out, port/PERIPHERAL_PIN_SELECT
always @* begin
    for (i = 0; i < 8; i = i + 1) begin
        if (cfg_own_in[i]) begin
            drv_val[i] = cfg_out_in[i];
            drv_en[i] = cfg_oe_in[i];
        end else if (analog_out_en_in[i]) begin
            drv_val[i] = 1'b0;
            drv_en[i] = 1'b0;
        end else begin
            // Latch by default, PERIPHERAL_PIN_SELECT only when selected; analog select ignored
            drv_val[i] = pps_sel_in[i] ? pps_out_in[i] : latch_reg[i];
            drv_en[i] = ~dir_reg[i];
            if (od_reg[i]) begin
                // Sink only: drive low while value is 0
                drv_en[i] = ~dir_reg[i] & ~drv_val[i];
                drv_val[i] = 1'b0;
            end
        end
        // Input-only pin never drives
        if (HAS_MASTER_CLEAR_PIN && i == MASTER_CLEAR_PIN_BIT) begin
            drv_en[i] = 1'b0;
            drv_val[i] = 1'b0;
        end
    end
    drv_en = drv_en & IMPL_MASK;
    drv_val = drv_val & IMPL_MASK;
    pu_eff = pullup_reg & dir_reg & IMPL_MASK;
    if (HAS_MASTER_CLEAR_PIN && ((master_clear_enable_in && !low_voltage_prog_enable_in)
                     || low_voltage_prog_enable_in))
        pu_eff[MASTER_CLEAR_PIN_BIT] = 1'b1;
end

// Registered pad outputs
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        pin_out <= 8'h00;
        pin_oe_out <= 8'h00;
        pullup_enable_out <= 8'h00;
        slew_limit_out <= 8'h00;
        i2c_slew_out <= 8'h00;
        i2c_pullup_out <= 16'h0000;
        i2c_threshold_out <= 16'h0000;
        periph_in_out <= 8'h00;
    end else begin
        pin_out <= drv_val;
        pin_oe_out <= drv_en;
        pullup_enable_out <= pu_eff;
        for (k = 0; k < 8; k = k + 1) begin
            // I2C slew replaces standard slew when enabled
            i2c_slew_out[k] <= I2C_PAD_MASK[k] & i2c_pad_reg[k][`GPP_I2C_SLEW_BIT];
            slew_limit_out[k] <= IMPL_MASK[k] & slew_reg[k]
                & ~(I2C_PAD_MASK[k] & i2c_pad_reg[k][`GPP_I2C_SLEW_BIT]);
            i2c_pullup_out[2*k +: 2] <= I2C_PAD_MASK[k] ?
                i2c_pad_reg[k][`GPP_I2C_PU_HI:`GPP_I2C_PU_LO] : 2'b00;
            i2c_threshold_out[2*k +: 2] <= I2C_PAD_MASK[k] ?
                i2c_pad_reg[k][`GPP_I2C_TH_HI:`GPP_I2C_TH_LO] : 2'b00;
        end
        periph_in_out <= periph_level;
    end
end

// ----------------------------------------
// Edge detection
// ----------------------------------------
wire [7:0] rise_evt = dig_level & ~prev_reg & rise_en_reg & {8{prev_valid_reg}};
wire [7:0] fall_evt = ~dig_level & prev_reg & fall_en_reg & {8{prev_valid_reg}};
wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
wire bus_wr = bus_req & wb_we_in & wb_sel_in[0];
wire [7:0] flag_clr = (bus_wr && wb_adr_in == `GPP_OFS_EDGE_FLAGS) ? wb_dat_in[7:0] : 8'h00;

// Sticky flags; a new edge wins over a write-one clear
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        prev_reg <= 8'h00;
        prev_valid_reg <= 1'b0;
        flags_reg <= 8'h00;
        edge_flags_out <= 8'h00;
    end else begin
        prev_reg <= dig_level;
        prev_valid_reg <= 1'b1;
        flags_reg <= ((flags_reg & ~flag_clr) | rise_evt | fall_evt) & IMPL_MASK;
        edge_flags_out <= ((flags_reg & ~flag_clr) | rise_evt | fall_evt) & IMPL_MASK;
    end
end

// ----------------------------------------
// Output latch
// ----------------------------------------
// Only power-on clears the latch; other resets leave it alone
always @(posedge mclk_in) begin
    if (por_in)
        latch_reg <= 8'h00;
    else if (bus_wr && (wb_adr_in == `GPP_OFS_LATCH || wb_adr_in == `GPP_OFS_PIN_LEVEL))
        latch_reg <= wr_byte(latch_reg, wb_dat_in, wb_sel_in) & IMPL_MASK & ~fixed_mask;
end

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        dir_reg <= `GPP_RST_DIRECTION & IMPL_MASK;
        analog_reg <= `GPP_RST_ANALOG & IMPL_MASK;
        pullup_reg <= `GPP_RST_PULLUP;
        thresh_reg <= `GPP_RST_THRESHOLD & IMPL_MASK;
        slew_reg <= `GPP_RST_SLEW & IMPL_MASK;
        od_reg <= `GPP_RST_OPEN_DRAIN;
        rise_en_reg <= 8'h00;
        fall_en_reg <= 8'h00;
        i2c_idx_reg <= 3'h0;
        for (m = 0; m < 8; m = m + 1)
            i2c_pad_reg[m] <= `GPP_RST_I2C_PAD;
    end else if (bus_wr) begin
        case (wb_adr_in)
            `GPP_OFS_DIRECTION: dir_reg <= (wb_dat_in[7:0] | fixed_mask) & IMPL_MASK;
            `GPP_OFS_ANALOG: analog_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_PULLUP: pullup_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_THRESHOLD: thresh_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_SLEW: slew_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_OPEN_DRAIN: od_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_EDGE_RISE: rise_en_reg <= wb_dat_in[7:0] & IMPL_MASK;
            `GPP_OFS_EDGE_FALL: fall_en_reg <= wb_dat_in[7:0] & IMPL_MASK;
            // Pad control: bits 10:8 pick the pin, 7:0 the settings
            `GPP_OFS_I2C_PAD: begin
                i2c_idx_reg <= wb_dat_in[10:8];
                if (I2C_PAD_MASK[wb_dat_in[10:8]])
                    i2c_pad_reg[wb_dat_in[10:8]] <= wb_dat_in[7:0] & `GPP_I2C_MASK;
            end
            default: ;
        endcase
    end
end

// ----------------------------------------
// Wishbone slave
// ----------------------------------------
reg [7:0] rd_byte;
reg rd_hit;

// Read mux; unimplemented bits come back as zero
always @* begin
    rd_hit = 1'b1;
    case (wb_adr_in)
        `GPP_OFS_PIN_LEVEL: rd_byte = port_read;
        `GPP_OFS_LATCH: rd_byte = latch_reg;
        `GPP_OFS_DIRECTION: rd_byte = dir_reg;
        `GPP_OFS_ANALOG: rd_byte = analog_reg;
        `GPP_OFS_PULLUP: rd_byte = pullup_reg;
        `GPP_OFS_THRESHOLD: rd_byte = thresh_reg;
        `GPP_OFS_SLEW: rd_byte = slew_reg;
        `GPP_OFS_OPEN_DRAIN: rd_byte = od_reg;
        `GPP_OFS_EDGE_RISE: rd_byte = rise_en_reg;
        `GPP_OFS_EDGE_FALL: rd_byte = fall_en_reg;
        `GPP_OFS_EDGE_FLAGS: rd_byte = flags_reg;
        `GPP_OFS_I2C_PAD: rd_byte = i2c_pad_reg[i2c_idx_reg];
        default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    endcase
end

// One-cycle answer; unmapped addresses get err instead of ack
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        wb_ack_out <= 1'b0;
        wb_err_out <= 1'b0;
        wb_dat_out <= 32'h0000_0000;
    end else begin
        wb_ack_out <= bus_req & rd_hit;
        wb_err_out <= bus_req & ~rd_hit;
        wb_dat_out <= (bus_req & rd_hit & ~wb_we_in) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
end

endmodule // gpp_port

// ---- dv/gpp_pins_model.sv ----
/*
 * Board-side model of the eight port pins: resolves each pin from the port's
 * drive, an external driver, the weak pull-up or nothing at all.
 * Assumes the bench drives the external side and never fights the port.
 */
module gpp_pins_model (
    input wire logic clk_in,
    input wire logic [7:0] drv_out_in,
    input wire logic [7:0] drv_oe_in,
    input wire logic [7:0] pull_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    input wire logic [7:0] mid_in,
    output logic [7:0] schmitt_out,
    output logic [7:0] ttl_out,
    output logic [7:0] i2c_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_reg = 8'h55;
    logic [7:0] level;
    // --------------------------------
    // Pin resolution
    // --------------------------------
    // Floating pins wander every cycle so a stale level never passes as real
    always @(posedge clk_in) begin
        float_reg <= ~float_reg;
    end
    // Port drive first, then board, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = drv_oe_in[i] ? drv_out_in[i] : ext_en_in[i] ? ext_val_in[i] :
                pull_in[i] ? 1'b1 : float_reg[i];
        end
    end
    // Mid-rail levels read differently through the two thresholds
    assign schmitt_out = level;
    assign ttl_out = level ^ mid_in;
    assign i2c_out = level;
endmodule // gpp_pins_model

// ---- dv/gpp_port_sva.sv ----
/*
 * Port-level checker for the GPIO port: bus handshake and pin drive rules.
 * Assumes the fixed-function and peripheral drive inputs stay low.
 */
module gpp_port_sva (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    input wire logic [31:0] wb_dat_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [7:0] pullup_enable_out,
    input wire logic [7:0] analog_out_en_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // --------------------------------
    // Assertions
    // --------------------------------
    a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    a_resp_has_cause: assert property ((wb_ack_out || wb_err_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("answer without a request");
    a_answer_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out
        |=> wb_ack_out || wb_err_out) else $error("request not answered next cycle");
    a_single_resp: assert property (!(wb_ack_out && wb_err_out))
        else $error("ack and err together");
    a_data_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h00000000)
        else $error("read data outside an ack");
    a_inputs_after_reset: assert property ($rose(nrst_in) |-> pin_oe_out == 8'h00)
        else $error("pin driven right after reset");
    a_pullup_off_out: assert property ((pullup_enable_out & pin_oe_out) == 8'h00)
        else $error("pull-up on a driven pin");
    a_analog_out_hiz: assert property
        (($past(analog_out_en_in) & $past(analog_out_en_in, 2) & pin_oe_out) == 8'h00)
        else $error("digital drive under analog output");
endmodule // gpp_port_sva

bind gpp_port gpp_port_sva u_sva (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .wb_err_out(wb_err_out), .wb_dat_out(wb_dat_out), .pin_oe_out(pin_oe_out),
    .pullup_enable_out(pullup_enable_out), .analog_out_en_in(analog_out_en_in));

// ---- dv/gpp_port_tb.sv ----
/*
 * Self-checking bench for the GPIO port: Wishbone register tasks, pin model.
 * Assumes default parameters for uut (eight pins, no master-clear pin); uut_mc adds one on bit 3.
 */
module gpp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 0, nrst_in = 0, por_in = 1, cyc = 0, stb = 0, we = 0, rerr = 0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat = 32'h0;
    logic [7:0] aout = 8'h00, peripheral_pin_select = 8'h00, mode = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] mid = 8'h00;
    logic mce = 1, low_voltage_prog_enable = 0;
    logic [31:0] rdat2 = 32'h0;
    wire [31:0] dat2;
    wire ack2, err2;
    wire [7:0] oe2, pu2;
    logic [5:0] rst_adr [6] = '{6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c};
    logic [7:0] rst_val [6] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00};
    wire [31:0] dat_o;
    wire ack, err;
    wire [7:0] p_out, p_oe, pu, slew, per, flags, sch, ttl, i2c;
    int num_errors = 0, checks_done = 0;
    always #2.5 mclk_in = ~mclk_in;
    gpp_port uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .por_in(por_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
        .wb_dat_out(dat_o), .wb_ack_out(ack), .wb_err_out(err), .pin_in(sch),
        .pin_ttl_in(ttl), .pin_i2c_in(i2c), .pin_out(p_out), .pin_oe_out(p_oe),
        .pullup_enable_out(pu), .slew_limit_out(slew), .i2c_slew_out(), .i2c_pullup_out(),
        .i2c_threshold_out(), .periph_in_out(per), .edge_flags_out(flags),
        .analog_out_en_in(aout), .cfg_own_in(8'h00), .cfg_oe_in(8'h00), .cfg_out_in(8'h00),
        .pps_sel_in(peripheral_pin_select), .pps_out_in(8'h00), .i2c_mode_in(mode),
        .master_clear_enable_in(mce), .low_voltage_prog_enable_in(low_voltage_prog_enable));
    gpp_pins_model pins (.clk_in(mclk_in), .drv_out_in(p_out), .drv_oe_in(p_oe), .pull_in(pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .mid_in(mid), .schmitt_out(sch),
        .ttl_out(ttl), .i2c_out(i2c));
    // Same bus, master-clear pin on bit 3; answers in lock-step with uut
    gpp_port #(.HAS_MASTER_CLEAR_PIN(1'b1)) uut_mc (.mclk_in(mclk_in), .nrst_in(nrst_in), .por_in(por_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_dat_out(dat2), .wb_ack_out(ack2), .wb_err_out(err2),
        .pin_in(sch), .pin_ttl_in(ttl), .pin_i2c_in(i2c), .pin_out(), .pin_oe_out(oe2),
        .pullup_enable_out(pu2), .slew_limit_out(), .i2c_slew_out(), .i2c_pullup_out(),
        .i2c_threshold_out(), .periph_in_out(), .edge_flags_out(),
        .analog_out_en_in(8'h00), .cfg_own_in(8'h00), .cfg_oe_in(8'h00), .cfg_out_in(8'h00),
        .pps_sel_in(8'h00), .pps_out_in(8'h00), .i2c_mode_in(8'h00),
        .master_clear_enable_in(mce), .low_voltage_prog_enable_in(low_voltage_prog_enable));
    // --------------------------------
    // Bus and compare tasks
    // --------------------------------
    // Holds the request until ack or err is sampled, then idles one cycle
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge mclk_in);
        end while (ack !== 1'b1 && err !== 1'b1);
        rdat = dat_o;
        rdat2 = dat2;
        rerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string name);
        wb(1'b0, a, 8'h00);
        chk(name, exp, rdat[7:0]);
    endtask
    // Pin paths lag by synchroniser and output registers
    task automatic settle;
        repeat (6) @(posedge mclk_in);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // --------------------------------
    // Test sequence
    // --------------------------------
    initial begin
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        por_in <= 1'b0;
        foreach (rst_adr[i]) rd(rst_adr[i], rst_val[i], "reset value");
        chk("master_clear_pin pull-up", 8'h08, pu2);
        wb(1'b1, 6'h00, 8'h5a);
        rd(6'h04, 8'h5a, "latch via pin level");
        wb(1'b1, 6'h04, 8'ha5);
        wb(1'b1, 6'h0c, 8'h00);
        wb(1'b1, 6'h08, 8'h00);
        settle;
        chk("drive enable", 8'hff, p_oe);
        chk("master_clear_pin pin input only", 8'hf7, oe2);
        chk("drive value", 8'ha5, p_out);
        rd(6'h00, 8'ha5, "pin level");
        wb(1'b1, 6'h0c, 8'hff);
        settle;
        chk("drive under analog", 8'hff, p_oe);
        rd(6'h00, 8'h00, "analog pin level");
        chk("master_clear_pin pin level", 8'h08, rdat2[7:0]);
        chk("analog periph in", 8'h00, per);
        wb(1'b1, 6'h0c, 8'h00);
        wb(1'b1, 6'h1c, 8'hff);
        settle;
        chk("open drain enable", 8'h5a, p_oe);
        chk("open drain value", 8'h00, p_out);
        wb(1'b1, 6'h1c, 8'h00);
        aout <= 8'h01;
        settle;
        chk("analog out drive", 8'hfe, p_oe);
        aout <= 8'h00;
        wb(1'b1, 6'h10, 8'hff);
        wb(1'b1, 6'h08, 8'h0f);
        settle;
        chk("pull-up effective", 8'h0f, pu);
        rd(6'h10, 8'hff, "pull-up stored");
        wb(1'b1, 6'h18, 8'h00);
        settle;
        chk("slew", 8'h00, slew);
        wb(1'b1, 6'h08, 8'hff);
        wb(1'b1, 6'h10, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'h0f;
        mid <= 8'hff;
        settle;
        rd(6'h00, 8'h0f, "schmitt level");
        wb(1'b1, 6'h14, 8'h00);
        settle;
        rd(6'h00, 8'hf0, "ttl level");
        chk("ttl periph in", 8'hf0, per);
        wb(1'b1, 6'h14, 8'hff);
        mid <= 8'h00;
        ext_val <= 8'h02;
        wb(1'b1, 6'h20, 8'h01);
        wb(1'b1, 6'h24, 8'h02);
        wb(1'b1, 6'h28, 8'hff);
        ext_val <= 8'h01;
        settle;
        ext_val <= 8'h02;
        settle;
        rd(6'h28, 8'h03, "edge flags");
        chk("edge flags out", 8'h03, flags);
        wb(1'b1, 6'h28, 8'h03);
        rd(6'h28, 8'h00, "edge flags cleared");
        wb(1'b0, 6'h30, 8'h00);
        chk("unmapped err", 8'h01, {7'h00, rerr});
        wb(1'b1, 6'h04, 8'h3c);
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd(6'h04, 8'h3c, "latch kept");
        nrst_in <= 1'b0;
        por_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        por_in <= 1'b0;
        rd(6'h04, 8'h00, "latch after power-on");
        end_of_test;
    end
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk_in);
        num_errors++;
        end_of_test;
    end
endmodule // gpp_port_tb
